/* File: sfl_pkg.sv */
package sfl_pkg;

  // ---------------------------------------------------------------
  // Command opcodes
  // ---------------------------------------------------------------
  localparam logic [7:0] OP_ARRAY_READ_LEGACY = 8'hE8;
  localparam logic [7:0] OP_ARRAY_READ_FAST = 8'h0B;
  localparam logic [7:0] OP_ARRAY_READ_SLOW = 8'h03;
  localparam logic [7:0] OP_PAGE_READ = 8'hD2;
  localparam logic [7:0] OP_BUF1_READ = 8'hD4;
  localparam logic [7:0] OP_BUF2_READ = 8'hD6;
  localparam logic [7:0] OP_BUF1_READ_SLOW = 8'hD1;
  localparam logic [7:0] OP_BUF2_READ_SLOW = 8'hD3;
  localparam logic [7:0] OP_PROTECT_READ = 8'h32;
  localparam logic [7:0] OP_LOCKDOWN_READ = 8'h35;
  localparam logic [7:0] OP_SECURITY_READ = 8'h77;
  localparam logic [7:0] OP_STATUS_READ = 8'hD7;
  localparam logic [7:0] OP_IDENT_READ = 8'h9F;

  // ---------------------------------------------------------------
  // Bytes between the opcode and the first output bit
  // ---------------------------------------------------------------
  localparam logic [2:0] HDR_NONE = 3'h0;
  localparam logic [2:0] HDR_ADDR = 3'h3;
  localparam logic [2:0] HDR_ADDR_DUMMY1 = 3'h4;
  localparam logic [2:0] HDR_ADDR_DUMMY4 = 3'h7;

  // ---------------------------------------------------------------
  // Sizes and reset values
  // ---------------------------------------------------------------
  localparam int DATA_WIDTH = 8;
  localparam int FIFO_DEPTH = 8;
  localparam logic PAGE_512_RESET = 1'b0;
  localparam logic [7:0] IDLE_OUT_BYTE = 8'hFF;

  typedef enum logic [3:0] {
    SFL_CMD_NONE,
    SFL_CMD_ARRAY_READ,
    SFL_CMD_PAGE_READ,
    SFL_CMD_BUF1_READ,
    SFL_CMD_BUF2_READ,
    SFL_CMD_PROTECT_READ,
    SFL_CMD_LOCKDOWN_READ,
    SFL_CMD_SECURITY_READ,
    SFL_CMD_STATUS_READ,
    SFL_CMD_IDENT_READ,
    SFL_CMD_UNKNOWN
  } sfl_cmd_type;

  typedef enum logic [1:0] {
    SFL_ST_OPCODE,
    SFL_ST_HEADER,
    SFL_ST_DATA,
    SFL_ST_IGNORE
  } sfl_state_type;

endpackage

/* File: sfl_fifo.sv */
`timescale 1ns/1ps

module sfl_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire logic [WIDTH-1:0] in_data_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  output logic [WIDTH-1:0] out_data_out,
  output logic out_valid_out,
  input wire logic out_ready_in
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic [AW:0] next_count;
  wire push = in_valid_in && in_ready_out;
  wire pop = out_valid_out && out_ready_in;

  // Flags are registered from the next count, so both stay honest
  always_comb begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + (AW+1)'(1);
    end else if (pop && !push) begin
      next_count = count - (AW+1)'(1);
    end
  end

  assign out_data_out = mem[rd_ptr];

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready_out <= 1'b1;
      out_valid_out <= 1'b0;
    end else begin
      count <= next_count;
      in_ready_out <= next_count != DEPTH_C;
      out_valid_out <= next_count != '0;
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + AW'(1);
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + AW'(1);
      end
    end
  end

  // Storage needs no reset; only valid words are ever read out
  always_ff @(posedge ref_clk_in) begin
    if (push) begin
      mem[wr_ptr] <= in_data_in;
    end
  end

endmodule // sfl_fifo

/* File: sfl_link.sv */
`timescale 1ns/1ps


module sfl_link
  import sfl_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire logic device_select_n_in,
  input wire logic serial_clock_in,
  input wire logic serial_in_in,
  input wire logic factory_512_in,
  input wire logic page_cfg_512_in,
  input wire logic [7:0] tx_data_in,
  input wire logic tx_valid_in,
  output logic tx_ready_out,
  output logic serial_out_out,
  output logic serial_out_oe_out,
  output logic [7:0] rx_byte_out,
  output logic rx_valid_out,
  output sfl_cmd_type cmd_out,
  output logic cmd_valid_out,
  output logic page_size_512_out
);

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [2:0] sck_sync;
  logic [1:0] sel_sync;
  logic [2:0] si_sync;
  logic [1:0] strap_sync;

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sck_sync <= '0;
      sel_sync <= 2'h3;
      si_sync <= '0;
    end else begin
      sck_sync <= {sck_sync[1:0], serial_clock_in};
      sel_sync <= {sel_sync[0], device_select_n_in};
      si_sync <= {si_sync[1:0], serial_in_in};
    end
  end

  // Strap sampler runs through reset, so its level is settled at release
  always_ff @(posedge ref_clk_in) begin
    strap_sync <= {strap_sync[0], factory_512_in};
  end

  // Edges are found on stages two and three only; the data bit is the one
  // seen just before the rising edge, so a host changing the line on that
  // same edge cannot corrupt it.
  wire selected = !sel_sync[1];
  wire sck_rise = sck_sync[1] && !sck_sync[2];
  wire sck_fall = !sck_sync[1] && sck_sync[2];
  wire si_bit = si_sync[2];

  // ---------------------------------------------------------------
  // Output data buffer
  // ---------------------------------------------------------------
  logic [7:0] buf_data;
  logic buf_valid;
  logic buf_pop;

  sfl_fifo #(
    .WIDTH(DATA_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .ref_clk_in(ref_clk_in),
    .reset_n_in(reset_n_in),
    .in_data_in(tx_data_in),
    .in_valid_in(tx_valid_in),
    .in_ready_out(tx_ready_out),
    .out_data_out(buf_data),
    .out_valid_out(buf_valid),
    .out_ready_in(buf_pop)
  );

  // ---------------------------------------------------------------
  // Command decode
  // ---------------------------------------------------------------
  sfl_state_type state;
  logic [7:0] rx_shift;
  logic [2:0] rx_bit;
  logic [2:0] hdr_left;
  logic [2:0] tx_bit;
  logic [7:0] tx_shift;

  wire [7:0] rx_next = {rx_shift[6:0], si_bit};
  wire byte_done = sck_rise && (rx_bit == 3'h7);

  sfl_cmd_type dec_cmd;
  logic [2:0] dec_hdr;

  always_comb begin
    dec_cmd = SFL_CMD_UNKNOWN;
    dec_hdr = HDR_NONE;
    case (rx_next)
      OP_ARRAY_READ_LEGACY: begin
        dec_cmd = SFL_CMD_ARRAY_READ;
        dec_hdr = HDR_ADDR_DUMMY4;
      end
      OP_ARRAY_READ_FAST: begin
        dec_cmd = SFL_CMD_ARRAY_READ;
        dec_hdr = HDR_ADDR_DUMMY1;
      end
      OP_ARRAY_READ_SLOW: begin
        dec_cmd = SFL_CMD_ARRAY_READ;
        dec_hdr = HDR_ADDR;
      end
      OP_PAGE_READ: begin
        dec_cmd = SFL_CMD_PAGE_READ;
        dec_hdr = HDR_ADDR_DUMMY4;
      end
      OP_BUF1_READ: begin
        dec_cmd = SFL_CMD_BUF1_READ;
        dec_hdr = HDR_ADDR_DUMMY1;
      end
      OP_BUF2_READ: begin
        dec_cmd = SFL_CMD_BUF2_READ;
        dec_hdr = HDR_ADDR_DUMMY1;
      end
      OP_BUF1_READ_SLOW: begin
        dec_cmd = SFL_CMD_BUF1_READ;
        dec_hdr = HDR_ADDR;
      end
      OP_BUF2_READ_SLOW: begin
        dec_cmd = SFL_CMD_BUF2_READ;
        dec_hdr = HDR_ADDR;
      end
      OP_PROTECT_READ: begin
        dec_cmd = SFL_CMD_PROTECT_READ;
        dec_hdr = HDR_ADDR;
      end
      OP_LOCKDOWN_READ: begin
        dec_cmd = SFL_CMD_LOCKDOWN_READ;
        dec_hdr = HDR_ADDR;
      end
      OP_SECURITY_READ: begin
        dec_cmd = SFL_CMD_SECURITY_READ;
        dec_hdr = HDR_ADDR;
      end
      OP_STATUS_READ: begin
        dec_cmd = SFL_CMD_STATUS_READ;
      end
      OP_IDENT_READ: begin
        dec_cmd = SFL_CMD_IDENT_READ;
      end
      default: begin
        dec_cmd = SFL_CMD_UNKNOWN;
      end
    endcase
  end

  // Output shifting only in the data phase, so the lone falling edge that
  // opens a mode 3 frame launches nothing.
  wire in_data = selected && (state == SFL_ST_DATA);
  wire tx_load = in_data && sck_fall && (tx_bit == 3'h0);
  wire [7:0] tx_byte = buf_valid ? buf_data : IDLE_OUT_BYTE;
  assign buf_pop = tx_load && buf_valid;

  // ---------------------------------------------------------------
  // Frame state
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state <= SFL_ST_OPCODE;
      rx_shift <= '0;
      rx_bit <= '0;
      hdr_left <= '0;
      rx_byte_out <= '0;
      rx_valid_out <= 1'b0;
      cmd_out <= SFL_CMD_NONE;
      cmd_valid_out <= 1'b0;
    end else begin
      rx_valid_out <= 1'b0;
      cmd_valid_out <= 1'b0;
      if (!selected) begin
        state <= SFL_ST_OPCODE;
        rx_bit <= '0;
        hdr_left <= '0;
      end else if (sck_rise) begin
        rx_shift <= rx_next;
        rx_bit <= rx_bit + 3'h1;
        if (byte_done) begin
          rx_byte_out <= rx_next;
          rx_valid_out <= 1'b1;
          case (state)
            SFL_ST_OPCODE: begin
              cmd_out <= dec_cmd;
              cmd_valid_out <= 1'b1;
              hdr_left <= dec_hdr;
              if (dec_cmd == SFL_CMD_UNKNOWN) begin
                state <= SFL_ST_IGNORE;
              end else if (dec_hdr == HDR_NONE) begin
                state <= SFL_ST_DATA;
              end else begin
                state <= SFL_ST_HEADER;
              end
            end
            SFL_ST_HEADER: begin
              hdr_left <= hdr_left - 3'h1;
              if (hdr_left == 3'h1) begin
                state <= SFL_ST_DATA;
              end
            end
            SFL_ST_DATA: begin
              state <= SFL_ST_DATA;
            end
            default: begin
              state <= SFL_ST_IGNORE;
            end
          endcase
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Serial output
  // ---------------------------------------------------------------
  // Launch comes about three reference cycles after the falling edge,
  // well inside the clock_low_phase at the bench rate; faster link
  // clocks than the reference can follow are not supported.
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tx_bit <= '0;
      tx_shift <= '0;
      serial_out_out <= 1'b0;
      serial_out_oe_out <= 1'b0;
    end else begin
      serial_out_oe_out <= in_data;
      if (!in_data) begin
        tx_bit <= '0;
      end else if (sck_fall) begin
        tx_bit <= tx_bit + 3'h1;
        if (tx_load) begin
          serial_out_out <= tx_byte[7];
          tx_shift <= {tx_byte[6:0], 1'b0};
        end else begin
          serial_out_out <= tx_shift[7];
          tx_shift <= {tx_shift[6:0], 1'b0};
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Page size
  // ---------------------------------------------------------------
  logic strap_taken;

  // Strap caught by a clocked process once reset has gone
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      strap_taken <= 1'b0;
      page_size_512_out <= PAGE_512_RESET;
    end else begin
      strap_taken <= 1'b1;
      if (!strap_taken) begin
        page_size_512_out <= strap_sync[1];
      end else if (page_cfg_512_in) begin
        page_size_512_out <= 1'b1;
      end
    end
  end

endmodule // sfl_link

/* File: sfl_link_monitor.sv */
`timescale 1ns/1ps

// ---------------------------------------------------------------
// Link checker
// ---------------------------------------------------------------
module sfl_link_monitor
  import sfl_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire logic device_select_n_in,
  input wire logic serial_clock_in,
  input wire logic factory_512_in,
  input wire logic page_cfg_512_in,
  input wire logic serial_out_out,
  input wire logic serial_out_oe_out,
  input wire logic rx_valid_out,
  input wire sfl_cmd_type cmd_out,
  input wire logic cmd_valid_out,
  input wire logic page_size_512_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in);

  a_oe_release:
    assert property ($rose(device_select_n_in) |-> ##[1:5] !serial_out_oe_out)
    else $error("output kept driven after select rose");
  a_oe_idle:
    assert property (device_select_n_in [*6] |-> !serial_out_oe_out)
    else $error("output driven while deselected");
  a_out_launch:
    assert property ($changed(serial_out_out) && $past(serial_out_oe_out)
      && serial_out_oe_out |-> !$past(serial_clock_in, 2))
    else $error("output bit not launched after a falling edge");
  a_rx_rise:
    assert property (rx_valid_out |-> $past(serial_clock_in, 2))
    else $error("byte completed away from a rising edge");
  a_rx_pulse:
    assert property (rx_valid_out |=> !rx_valid_out)
    else $error("byte strobe longer than one cycle");
  a_cmd_byte:
    assert property (cmd_valid_out |-> rx_valid_out && cmd_out != SFL_CMD_NONE)
    else $error("command strobe without a decoded byte");
  a_cmd_select:
    assert property (cmd_valid_out |-> !device_select_n_in)
    else $error("command decoded while deselected");
  a_oe_after_byte:
    assert property ($rose(serial_out_oe_out) |-> $past(rx_valid_out))
    else $error("data phase began without a completed byte");
  a_page_cause:
    assert property ($rose(page_size_512_out) |-> $past(page_cfg_512_in)
      || $past(page_cfg_512_in, 2) || $past(factory_512_in))
    else $error("page size changed without a cause");
  a_page_keep:
    assert property (page_size_512_out |=> page_size_512_out)
    else $error("page size fell back without reset");
endmodule // sfl_link_monitor

bind sfl_link sfl_link_monitor mon (.ref_clk_in(ref_clk_in),
  .reset_n_in(reset_n_in), .device_select_n_in(device_select_n_in),
  .serial_clock_in(serial_clock_in), .factory_512_in(factory_512_in),
  .page_cfg_512_in(page_cfg_512_in), .serial_out_out(serial_out_out),
  .serial_out_oe_out(serial_out_oe_out), .rx_valid_out(rx_valid_out),
  .cmd_out(cmd_out), .cmd_valid_out(cmd_valid_out),
  .page_size_512_out(page_size_512_out));

/* File: sfl_host.sv */
`timescale 1ns/1ps

// ---------------------------------------------------------------
// Host side of the link
// ---------------------------------------------------------------
module sfl_host (
  output logic sel_n_out,
  output logic sclk_out,
  output logic si_out,
  input wire logic so_in
);
  initial begin
    sel_n_out = 1'b1;
    sclk_out = 1'b0;
    si_out = 1'b0;
  end

  // Refresh duty: the pointed page is rewritten before a sector collects
  // the limit of page operations since its last full pass
  localparam int REFRESH_LIMIT = 10000;
  int refresh_ptr = 0;
  int sector_ops = 0;

  // One page written, directly or through a buffer, in sequence
  task automatic page_done(input int pages_in_sector);
    sector_ops++;
    if (sector_ops >= REFRESH_LIMIT / pages_in_sector) begin
      refresh_ptr = (refresh_ptr + 1) % pages_in_sector;
      sector_ops = 0;
    end
  endtask

  // Full-period transfer both ways; the clock stands still between frames
  task automatic frame(input logic mode3, input int n,
      input logic [7:0] tx [12], output logic [7:0] rx [12]);
    #3 sclk_out = mode3;
    #100 sel_n_out = 1'b0;
    si_out = tx[0][7];
    if (mode3) #40 sclk_out = 1'b0;
    for (int j = 0; j < 8 * n; j++) begin
      #40 sclk_out = 1'b1;
      si_out = tx[(j + 1) / 8][7 - (j + 1) % 8];
      #40 rx[j / 8][7 - j % 8] = so_in;
      sclk_out = 1'b0;
    end
    #40 sel_n_out = 1'b1;
    si_out = ~si_out; // Released line must not keep a stale bit
  endtask
endmodule // sfl_host

/* File: serial_flash_host_link_timing_bench.sv */
`timescale 1ns/1ps

module serial_flash_host_link_timing_bench;
  import sfl_pkg::*;
  logic ref_clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic factory_512_in = 1'b0;
  logic page_cfg_512_in = 1'b0;
  logic [7:0] tx_data_in = 8'h00;
  logic tx_valid_in = 1'b0;
  logic sel_n, sclk, si;
  logic tx_ready_out, serial_out_out, serial_out_oe_out, rx_valid_out;
  logic cmd_valid_out, page_size_512_out;
  logic [7:0] rx_byte_out;
  sfl_cmd_type cmd_out;
  wire so_line = serial_out_oe_out ? serial_out_out : 1'bz;
  int fails = 0;
  int compares = 0;
  int cmd_seen = 0;
  int rx_seen = 0;
  logic [7:0] tx [12];
  logic [7:0] rx [12];

  initial forever #5 ref_clk_in = ~ref_clk_in;

  // Strobe counters, so the one-cycle pulses are judged too
  always @(posedge ref_clk_in) begin
    if (cmd_valid_out === 1'b1) cmd_seen++;
    if (rx_valid_out === 1'b1) rx_seen++;
  end

  sfl_link dut (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
    .device_select_n_in(sel_n), .serial_clock_in(sclk),
    .serial_in_in(si), .factory_512_in(factory_512_in),
    .page_cfg_512_in(page_cfg_512_in), .tx_data_in(tx_data_in),
    .tx_valid_in(tx_valid_in), .tx_ready_out(tx_ready_out),
    .serial_out_out(serial_out_out), .serial_out_oe_out(serial_out_oe_out),
    .rx_byte_out(rx_byte_out), .rx_valid_out(rx_valid_out),
    .cmd_out(cmd_out), .cmd_valid_out(cmd_valid_out),
    .page_size_512_out(page_size_512_out));

  sfl_host host (.sel_n_out(sel_n), .sclk_out(sclk), .si_out(si),
    .so_in(so_line));

  // ---------------------------------------------------------------
  // Compare and report
  // ---------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chkc(input sfl_cmd_type got, input sfl_cmd_type exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: command %0d not %0d", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    chk({7'h00, page_size_512_out}, 8'h00);
    chk({7'h00, tx_ready_out}, 8'h01);
    chk({7'h00, serial_out_oe_out}, 8'h00);
    chkc(cmd_out, SFL_CMD_NONE);
    $display("test reset done");
  endtask

  // Every opcode, alternating clock polarity at select fall
  task automatic t_decode();
    logic [7:0] ops [14] = '{8'hE8, 8'h0B, 8'h03, 8'hD2, 8'hD4, 8'hD6,
      8'hD1, 8'hD3, 8'h32, 8'h35, 8'h77, 8'hD7, 8'h9F, 8'hA5};
    sfl_cmd_type exp [14] = '{SFL_CMD_ARRAY_READ, SFL_CMD_ARRAY_READ,
      SFL_CMD_ARRAY_READ, SFL_CMD_PAGE_READ, SFL_CMD_BUF1_READ,
      SFL_CMD_BUF2_READ, SFL_CMD_BUF1_READ, SFL_CMD_BUF2_READ,
      SFL_CMD_PROTECT_READ, SFL_CMD_LOCKDOWN_READ, SFL_CMD_SECURITY_READ,
      SFL_CMD_STATUS_READ, SFL_CMD_IDENT_READ, SFL_CMD_UNKNOWN};
    int cmd0;
    int rx0;
    cmd0 = cmd_seen;
    rx0 = rx_seen;
    for (int i = 0; i < 14; i++) begin
      tx[0] = ops[i];
      host.frame(i[0], 1, tx, rx);
      repeat (4) @(posedge ref_clk_in);
      chkc(cmd_out, exp[i]);
      chk(rx_byte_out, ops[i]);
    end
    chk(8'(cmd_seen - cmd0), 8'h0E);
    chk(8'(rx_seen - rx0), 8'h0E);
    $display("test decode done");
  endtask

  // Four header bytes: the first data byte must come out as byte six
  task automatic t_header();
    int rx0;
    rx0 = rx_seen;
    @(posedge ref_clk_in);
    tx_valid_in <= 1'b1;
    tx_data_in <= 8'h5A;
    @(posedge ref_clk_in);
    tx_valid_in <= 1'b0;
    tx[0] = 8'h0B;
    host.frame(1'b0, 6, tx, rx);
    repeat (4) @(posedge ref_clk_in);
    chk(rx[5], 8'h5A);
    chk(8'(rx_seen - rx0), 8'h06);
    chkc(cmd_out, SFL_CMD_ARRAY_READ);
    $display("test header done");
  endtask

  // Fill the buffer until refused, then drain it past empty
  task automatic t_stream();
    int n;
    n = 0;
    for (int i = 0; i < 12; i++) begin
      @(posedge ref_clk_in);
      if (tx_valid_in && tx_ready_out) n++;
      tx_valid_in <= 1'b1;
      tx_data_in <= 8'hA0 + n[7:0];
    end
    tx_valid_in <= 1'b0;
    chk(n[7:0], 8'h08);
    @(posedge ref_clk_in);
    chk({7'h00, tx_ready_out}, 8'h00);
    tx[0] = 8'hD7;
    host.frame(1'b1, 10, tx, rx);
    for (int k = 1; k < 10; k++) begin
      chk(rx[k], k < 9 ? 8'hA0 + 8'(k - 1) : 8'hFF);
    end
    repeat (6) @(posedge ref_clk_in);
    chk({7'h00, serial_out_oe_out}, 8'h00);
    chkc(cmd_out, SFL_CMD_STATUS_READ);
    $display("test stream done");
  endtask

  task automatic t_page();
    @(posedge ref_clk_in);
    page_cfg_512_in <= 1'b1;
    @(posedge ref_clk_in);
    page_cfg_512_in <= 1'b0;
    repeat (3) @(posedge ref_clk_in);
    chk({7'h00, page_size_512_out}, 8'h01);
    reset_n_in <= 1'b0;
    factory_512_in <= 1'b1;
    repeat (4) @(posedge ref_clk_in);
    reset_n_in <= 1'b1;
    repeat (4) @(posedge ref_clk_in);
    chk({7'h00, page_size_512_out}, 8'h01);
    $display("test page done");
  endtask

  initial begin
    foreach (tx[i]) tx[i] = 8'h00;
    repeat (6) @(posedge ref_clk_in);
    reset_n_in <= 1'b1;
    repeat (6) @(posedge ref_clk_in);
    t_reset();
    t_decode();
    t_stream();
    t_header();
    t_page();
    summarize();
  end

  initial begin
    #200000;
    fails++;
    summarize();
  end
endmodule // serial_flash_host_link_timing_bench
